// ---- include/mtx_pkg.sv ----
package mtx_pkg;
  // Clocking: 125 MHz core, 25 MHz nibble clock made by division
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned MII_MHZ = 25;
  localparam logic [2:0] DIV_LAST = 3'(CLK_MHZ / MII_MHZ - 1);
  localparam logic [2:0] MCLK_HI = 3'h2;
  localparam logic [2:0] PH_TAKE = 3'h4;
  localparam logic [2:0] PH_RXOUT = 3'h1;

  // Register bus geometry and register numbers
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [4:0] REG_CTRL = 5'h10;
  localparam logic [4:0] REG_ADDR = 5'h11;
  localparam logic [4:0] REG_STAT = 5'h12;
  localparam logic [4:0] REG_TXCNT = 5'h13;
  localparam logic [4:0] REG_RXERR = 5'h14;

  // Field positions
  localparam int unsigned CTRL_BYP_BIT = 15;
  localparam int unsigned CTRL_RPT_BIT = 11;
  localparam int unsigned CTRL_FDX_BIT = 8;
  localparam int unsigned ADDR_HI_BIT = 8;
  localparam int unsigned ADDR_LO_BIT = 4;
  localparam int unsigned STAT_TX_BIT = 0;
  localparam int unsigned STAT_RX_BIT = 1;
  localparam int unsigned STAT_ISO_BIT = 2;
  localparam int unsigned STAT_TST_BIT = 3;

  // Reset values
  localparam logic FDX_RST = 1'b0;
  localparam logic [10:0] SCR_SEED = 11'h7FF;
  localparam logic [4:0] ISO_ADDR = 5'h00;

  // Code groups
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_I = 5'h1F;
  localparam logic [4:0] SYM_H = 5'h04;
  localparam logic [3:0] PRE_NIB = 4'h5;
  localparam logic [4:0] CODE_TAB [16] = '{
    5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_K = 4'h2,
    TX_DATA = 4'h4,
    TX_R = 4'h8
  } mtx_tx_state_type;

  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } mtx_mii_tx_type;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } mtx_mii_rx_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mtx_reg_req_type;

  // All pins that cross in from outside, synchronised together
  typedef struct packed {
    logic flt;
    logic tst;
    logic rpt;
    logic byp;
    logic [4:0] addr;
    mtx_mii_tx_type tx;
  } mtx_pin_type;
endpackage

// ---- src/mtx_mii_phy.sv ----
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
// What this block does
// - Address straps latched into register 17 reversed
// - Address zero isolates the MII outputs
// - Float input releases every MII output
// - Test select one enables test mode
// - Nibble taken each clock while enable high
// - Transmit and receive clocks run freely
// - Transmit error yields an invalid symbol
// - Receive nibble presented while data valid
// - Data valid spans frame, excludes end delimiter
// - Receive error flagged for bad symbols
// - Carrier sense follows transmit or receive
// - Repeater or full duplex: receive only
// - 25 MHz nibbles, 125 MHz symbol clock
// - Scrambled serial stream at 125 Msym/s
// - First preamble byte becomes J then K
// - Nibbles 0 to 15 mapped by table
// - End of enable inserts T then R
// - Idle code sent between frames
// - Encoder bypass passes raw symbols
// - Bypass strap latched into control bit 15
module mtx_mii_phy (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic strap_addr_bit0_i,
  input wire logic strap_addr_bit1_i,
  input wire logic strap_addr_bit2_i,
  input wire logic strap_addr_bit3_i,
  input wire logic strap_addr_bit4_i,
  input wire logic output_float_ctl_i,
  input wire logic test_select_i,
  input wire logic repeater_select_i,
  input wire logic coding_bypass_strap_i,
  input wire mtx_pkg::mtx_mii_tx_type mii_tx_i,
  input wire logic [4:0] rx_sym_i,
  input wire logic rx_sym_vld_i,
  input wire mtx_pkg::mtx_reg_req_type reg_req_i,
  output logic [15:0] reg_rdata_o,
  output logic tx_clk_o,
  output logic rx_clk_o,
  output mtx_pkg::mtx_mii_rx_type mii_rx_o,
  output logic crs_o,
  output logic mii_oe_o,
  output logic tx_ser_o
);

  typedef struct packed {
    mtx_pkg::mtx_pin_type s0;
    mtx_pkg::mtx_pin_type s1;
    mtx_pkg::mtx_pin_type s2;
    mtx_pkg::mtx_pin_type pin;
    logic [2:0] div;
    logic mclk;
    mtx_pkg::mtx_tx_state_type txs;
    logic [4:0] shf;
    logic [10:0] scr;
    logic ser;
    logic [4:0] lsym;
    logic lstb;
    logic rxf;
    mtx_pkg::mtx_mii_rx_type rxp;
    mtx_pkg::mtx_mii_rx_type rxo;
    logic [4:0] addr;
    logic byp;
    logic rpt;
    logic fdx;
    logic tst;
    logic crs;
    logic oe;
    logic [15:0] txcnt;
    logic [15:0] rxerr;
    logic [15:0] rdata;
  } mtx_state_type;

  mtx_state_type st_ff;
  mtx_state_type nxt_st;
  mtx_pkg::mtx_pin_type pins;
  logic iso;
  logic take;
  logic tx_act;
  logic [4:0] rsym;
  logic rstb;
  logic [4:0] sym;
  logic [4:0] dec;
  logic err_inc;
  logic frm_end;

  // Reverse code lookup; bit 4 of the result marks a data code
  function automatic logic [4:0] dec5b(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (mtx_pkg::CODE_TAB[i] == s) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Gather the asynchronous pins into one vector
  assign pins = '{flt: output_float_ctl_i, tst: test_select_i,
    rpt: repeater_select_i, byp: coding_bypass_strap_i,
    addr: {strap_addr_bit4_i, strap_addr_bit3_i, strap_addr_bit2_i,
           strap_addr_bit1_i, strap_addr_bit0_i},
    tx: mii_tx_i};

  // Shared decodes
  assign iso = (st_ff.addr == mtx_pkg::ISO_ADDR);
  assign take = (st_ff.div == mtx_pkg::PH_TAKE);
  assign tx_act = (st_ff.txs != mtx_pkg::TX_IDLE) | (st_ff.byp & st_ff.pin.tx.en & ~iso);
  // Test mode loops the encoder output into the decoder
  assign rsym = st_ff.tst ? st_ff.lsym : rx_sym_i;
  assign rstb = st_ff.tst ? st_ff.lstb : rx_sym_vld_i;

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    sym = mtx_pkg::SYM_I;
    dec = dec5b(rsym);
    err_inc = 1'b0;
    frm_end = 1'b0;
    // Three stages; a bit changes only once stages 2 and 3 agree
    nxt_st.s0 = pins;
    nxt_st.s1 = st_ff.s0;
    nxt_st.s2 = st_ff.s1;
    nxt_st.pin = mtx_pkg::mtx_pin_type'((st_ff.pin & (st_ff.s1 ^ st_ff.s2))
      | (st_ff.s2 & ~(st_ff.s1 ^ st_ff.s2)));
    // Divide by five: free 25 MHz clock for both MII directions
    nxt_st.div = (st_ff.div == mtx_pkg::DIV_LAST) ? 3'h0 : st_ff.div + 3'h1;
    nxt_st.mclk = (nxt_st.div < mtx_pkg::MCLK_HI);
    // Serialiser, bit 4 first, scrambled by an 11-bit LFSR
    nxt_st.ser = st_ff.shf[4] ^ st_ff.scr[10];
    nxt_st.shf = {st_ff.shf[3:0], 1'b0};
    nxt_st.scr = {st_ff.scr[9:0], st_ff.scr[10] ^ st_ff.scr[8]};
    nxt_st.lstb = 1'b0;
    // Nibble taken just before the rising MII clock edge
    if (take) begin
      case (st_ff.txs)
        mtx_pkg::TX_IDLE: begin
          if (st_ff.byp) begin
            // Raw five bits: error flag on top of the nibble
            if (st_ff.pin.tx.en && !iso) begin
              sym = {st_ff.pin.tx.er, st_ff.pin.tx.d};
            end
          end else if (st_ff.pin.tx.en && !iso) begin
            sym = mtx_pkg::SYM_J;
            nxt_st.txs = mtx_pkg::TX_K;
          end
        end
        mtx_pkg::TX_K: begin
          if (st_ff.pin.tx.en && !iso) begin
            sym = mtx_pkg::SYM_K;
            nxt_st.txs = mtx_pkg::TX_DATA;
          end else begin
            sym = mtx_pkg::SYM_T;
            nxt_st.txs = mtx_pkg::TX_R;
          end
        end
        mtx_pkg::TX_DATA: begin
          if (st_ff.pin.tx.en && !iso) begin
            if (st_ff.pin.tx.er) begin
              sym = mtx_pkg::SYM_H;
            end else begin
              sym = mtx_pkg::CODE_TAB[st_ff.pin.tx.d];
            end
          end else begin
            sym = mtx_pkg::SYM_T;
            nxt_st.txs = mtx_pkg::TX_R;
          end
        end
        mtx_pkg::TX_R: begin
          sym = mtx_pkg::SYM_R;
          frm_end = 1'b1;
          nxt_st.txs = mtx_pkg::TX_IDLE;
        end
        default: begin
          nxt_st.txs = mtx_pkg::TX_IDLE;
        end
      endcase
      // Idle fills every slot not claimed above
      nxt_st.shf = sym;
      nxt_st.lsym = sym;
      nxt_st.lstb = 1'b1;
    end
    // Receive: one code group per slot from the line decoder
    if (rstb) begin
      if (!st_ff.rxf) begin
        if (rsym == mtx_pkg::SYM_J) begin
          // J stands in for preamble, so valid covers the delimiter
          nxt_st.rxf = 1'b1;
          nxt_st.rxp = '{dv: 1'b1, er: 1'b0, d: mtx_pkg::PRE_NIB};
        end else begin
          nxt_st.rxp = '{dv: 1'b0, er: 1'b0, d: 4'h0};
        end
      end else if (rsym == mtx_pkg::SYM_T) begin
        // End delimiter never shows under valid
        nxt_st.rxf = 1'b0;
        nxt_st.rxp = '{dv: 1'b0, er: 1'b0, d: 4'h0};
      end else if (rsym == mtx_pkg::SYM_I) begin
        // Idle inside a frame: premature end, flag it
        nxt_st.rxf = 1'b0;
        nxt_st.rxp = '{dv: 1'b1, er: 1'b1, d: 4'h0};
        err_inc = 1'b1;
      end else if (rsym == mtx_pkg::SYM_K) begin
        nxt_st.rxp = '{dv: 1'b1, er: 1'b0, d: mtx_pkg::PRE_NIB};
      end else begin
        nxt_st.rxp = '{dv: 1'b1, er: ~dec[4], d: dec[3:0]};
        err_inc = ~dec[4];
      end
    end
    // Drive receive pins on the falling MII clock edge
    if (st_ff.div == mtx_pkg::PH_RXOUT) begin
      nxt_st.rxo = st_ff.rxp;
    end
    // Carrier sense; repeater or full duplex hide own transmit
    nxt_st.crs = st_ff.rxf | (tx_act & ~(st_ff.rpt | st_ff.fdx));
    nxt_st.oe = ~st_ff.pin.flt & ~iso;
    nxt_st.tst = st_ff.pin.tst;
    // Counters; an event in the read cycle is kept, not lost
    nxt_st.txcnt = ((reg_req_i.rd && reg_req_i.addr == mtx_pkg::REG_TXCNT) ? 16'h0000 : st_ff.txcnt)
      + {15'h0000, frm_end};
    nxt_st.rxerr = ((reg_req_i.rd && reg_req_i.addr == mtx_pkg::REG_RXERR) ? 16'h0000 : st_ff.rxerr)
      + {15'h0000, err_inc};
    // Register reads, data one cycle later; unmapped read zero
    nxt_st.rdata = 16'h0000;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        mtx_pkg::REG_CTRL: begin
          nxt_st.rdata[mtx_pkg::CTRL_BYP_BIT] = st_ff.byp;
          nxt_st.rdata[mtx_pkg::CTRL_RPT_BIT] = st_ff.rpt;
          nxt_st.rdata[mtx_pkg::CTRL_FDX_BIT] = st_ff.fdx;
        end
        mtx_pkg::REG_ADDR: begin
          // Bit order flipped: address bit 0 sits highest
          nxt_st.rdata[mtx_pkg::ADDR_HI_BIT:mtx_pkg::ADDR_LO_BIT] =
            {st_ff.addr[0], st_ff.addr[1], st_ff.addr[2], st_ff.addr[3], st_ff.addr[4]};
        end
        mtx_pkg::REG_STAT: begin
          nxt_st.rdata[mtx_pkg::STAT_TX_BIT] = tx_act;
          nxt_st.rdata[mtx_pkg::STAT_RX_BIT] = st_ff.rxf;
          nxt_st.rdata[mtx_pkg::STAT_ISO_BIT] = iso;
          nxt_st.rdata[mtx_pkg::STAT_TST_BIT] = st_ff.tst;
        end
        mtx_pkg::REG_TXCNT: begin
          nxt_st.rdata = st_ff.txcnt;
        end
        mtx_pkg::REG_RXERR: begin
          nxt_st.rdata = st_ff.rxerr;
        end
        default: begin
          nxt_st.rdata = 16'h0000;
        end
      endcase
    end
    // Control writes; address register is strap-only
    if (reg_req_i.wr && reg_req_i.addr == mtx_pkg::REG_CTRL) begin
      nxt_st.byp = reg_req_i.wdata[mtx_pkg::CTRL_BYP_BIT];
      nxt_st.rpt = reg_req_i.wdata[mtx_pkg::CTRL_RPT_BIT];
      nxt_st.fdx = reg_req_i.wdata[mtx_pkg::CTRL_FDX_BIT];
    end
    // Reset: synchronisers keep running so straps are settled
    if (srst_i) begin
      // Start at the last phase so the first clock high is full length
      nxt_st.div = mtx_pkg::DIV_LAST;
      nxt_st.mclk = 1'b0;
      nxt_st.txs = mtx_pkg::TX_IDLE;
      nxt_st.shf = mtx_pkg::SYM_I;
      nxt_st.scr = mtx_pkg::SCR_SEED;
      nxt_st.ser = 1'b0;
      nxt_st.lsym = mtx_pkg::SYM_I;
      nxt_st.lstb = 1'b0;
      nxt_st.rxf = 1'b0;
      nxt_st.rxp = '0;
      nxt_st.rxo = '0;
      nxt_st.addr = st_ff.pin.addr;
      nxt_st.byp = st_ff.pin.byp;
      nxt_st.rpt = st_ff.pin.rpt;
      nxt_st.fdx = mtx_pkg::FDX_RST;
      nxt_st.tst = 1'b0;
      nxt_st.crs = 1'b0;
      nxt_st.oe = 1'b0;
      nxt_st.txcnt = 16'h0000;
      nxt_st.rxerr = 16'h0000;
      nxt_st.rdata = 16'h0000;
    end
  end

  // One register stage for all state
  always_ff @(posedge sys_clk_i) begin
    st_ff <= nxt_st;
  end

  // Outputs all straight from flip-flops
  assign reg_rdata_o = st_ff.rdata;
  assign tx_clk_o = st_ff.mclk;
  assign rx_clk_o = st_ff.mclk;
  assign mii_rx_o = st_ff.rxo;
  assign crs_o = st_ff.crs;
  assign mii_oe_o = st_ff.oe;
  assign tx_ser_o = st_ff.ser;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  // Checks on the running block
  float_off_a: assert property (st_ff.pin.flt |=> !mii_oe_o)
    else $error("outputs driven while float requested");
  iso_off_a: assert property (iso |=> !mii_oe_o)
    else $error("outputs driven at isolation address");
  clk_period_a: assert property ($rose(tx_clk_o) |=> !$rose(tx_clk_o) [*4] ##1 $rose(tx_clk_o))
    else $error("mii clock period not five cycles");
  jk_start_a: assert property (take && st_ff.txs == mtx_pkg::TX_IDLE && st_ff.pin.tx.en && !iso && !st_ff.byp
    |=> st_ff.shf == mtx_pkg::SYM_J ##5 st_ff.shf == mtx_pkg::SYM_K)
    else $error("frame start not J then K");
  data_map_a: assert property (take && st_ff.txs == mtx_pkg::TX_DATA && st_ff.pin.tx.en && !st_ff.pin.tx.er
    && !iso |=> st_ff.shf == mtx_pkg::CODE_TAB[$past(st_ff.pin.tx.d)])
    else $error("data nibble wrongly coded");
  err_sym_a: assert property (take && st_ff.txs == mtx_pkg::TX_DATA && st_ff.pin.tx.en && st_ff.pin.tx.er
    && !iso |=> st_ff.shf == mtx_pkg::SYM_H)
    else $error("transmit error not sent as H");
  end_tr_a: assert property (take && st_ff.txs == mtx_pkg::TX_DATA && !st_ff.pin.tx.en
    |=> st_ff.shf == mtx_pkg::SYM_T ##5 st_ff.shf == mtx_pkg::SYM_R)
    else $error("frame end not T then R");
  idle_fill_a: assert property (take && st_ff.txs == mtx_pkg::TX_R
    |=> ##5 st_ff.shf == mtx_pkg::SYM_I || $past(st_ff.pin.tx.en))
    else $error("no idle after end delimiter");
  bypass_raw_a: assert property (take && st_ff.byp && st_ff.txs == mtx_pkg::TX_IDLE && st_ff.pin.tx.en
    && !iso |=> st_ff.shf == {$past(st_ff.pin.tx.er), $past(st_ff.pin.tx.d)})
    else $error("bypass did not pass raw symbol");
  crs_rx_a: assert property (st_ff.rxf |=> crs_o)
    else $error("carrier sense low during receive");
  crs_hide_a: assert property (!st_ff.rxf && (st_ff.rpt || st_ff.fdx) |=> !crs_o)
    else $error("carrier sense on transmit only");
  dv_end_a: assert property (rstb && st_ff.rxf && rsym == mtx_pkg::SYM_T
    |=> !st_ff.rxp.dv ##[1:5] !mii_rx_o.dv)
    else $error("data valid covers end delimiter");
  rx_err_a: assert property (rstb && st_ff.rxf && !dec[4] && rsym != mtx_pkg::SYM_T && rsym != mtx_pkg::SYM_K
    |=> ##[1:5] mii_rx_o.er)
    else $error("bad symbol not flagged");
endmodule

// ---- tb/mtx_mac_model.sv ----
`timescale 1ns/100ps
// Behavioural MAC: one nibble per transmit clock rise
module mtx_mac_model (
  input wire logic tx_clk_i,
  output mtx_pkg::mtx_mii_tx_type mii_tx_o,
  output logic busy_o
);
  logic [4:0] nib_q[$];
  initial begin
    mii_tx_o = '0;
    busy_o = 1'b0;
  end
  // Pins change on the rise so they settle a whole period before the take
  always @(posedge tx_clk_i) begin
    if (nib_q.size() > 0) begin
      mii_tx_o <= {1'b1, nib_q.pop_front()};
      busy_o <= 1'b1;
    end else begin
      // Not valid: inverse of the last nibble, never a stale copy
      mii_tx_o <= {2'b00, ~mii_tx_o.d};
      busy_o <= 1'b0;
    end
  end
endmodule

// ---- tb/mtx_mii_phy_tb_top.sv ----
`timescale 1ns/100ps
module mtx_mii_phy_tb_top;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [4:0] strap = 5'h00;
  logic flt = 1'b0;
  logic tst = 1'b0;
  logic rpt = 1'b0;
  logic byp = 1'b0;
  logic [4:0] rx_sym = 5'h00;
  logic rx_vld = 1'b0;
  mtx_pkg::mtx_reg_req_type req = '0;
  mtx_pkg::mtx_mii_tx_type mtx;
  mtx_pkg::mtx_mii_rx_type mrx;
  logic [15:0] rdata;
  logic tx_clk, rx_clk, crs, oe, ser;
  logic bits[$];
  logic [3:0] rxq[$];
  logic cap = 1'b0;
  logic crs_hi = 1'b0;
  int mismatches = 0;
  int check_count = 0;
  int ntx = 0;
  int nrx = 0;
  int rxer = 0;
  // Own copy of the data code table, kept apart from the design's
  logic [4:0] tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  always #4 sys_clk_i = ~sys_clk_i;

  mtx_mii_phy u_mtx_mii_phy (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .strap_addr_bit0_i(strap[0]),
    .strap_addr_bit1_i(strap[1]), .strap_addr_bit2_i(strap[2]), .strap_addr_bit3_i(strap[3]),
    .strap_addr_bit4_i(strap[4]), .output_float_ctl_i(flt), .test_select_i(tst), .repeater_select_i(rpt),
    .coding_bypass_strap_i(byp), .mii_tx_i(mtx), .rx_sym_i(rx_sym), .rx_sym_vld_i(rx_vld), .reg_req_i(req),
    .reg_rdata_o(rdata), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .mii_rx_o(mrx), .crs_o(crs), .mii_oe_o(oe),
    .tx_ser_o(ser));
  mtx_mac_model u_mtx_mac_model (.tx_clk_i(tx_clk), .mii_tx_o(mtx), .busy_o());

  // Serial capture, carrier seen during the capture window
  always @(posedge sys_clk_i) begin
    if (cap) begin
      bits.push_back(ser);
      crs_hi <= crs_hi | crs;
    end
  end
  // Receive nibbles as the MAC samples them, on the clock rise
  always @(posedge rx_clk) begin
    nrx++;
    if (mrx.dv && mrx.er) rxer++;
    else if (mrx.dv) rxq.push_back(mrx.d);
  end
  always @(posedge tx_clk) ntx++;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [4:0] s, input logic b, input logic r);
    srst_i <= 1'b1;
    strap <= s;
    byp <= b;
    rpt <= r;
    // Short stand-in for the long hold the board must give
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] v);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge sys_clk_i);
    req <= '0;
    // Let an edge pass so a following request never meets this clear
    @(posedge sys_clk_i);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [4:0] a, output logic [15:0] v);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk_i);
    req <= '0;
    #1 v = rdata;
    @(posedge sys_clk_i);
  endtask

  task automatic run_frame(input logic [4:0] nb[$]);
    int t;
    bits = {};
    crs_hi = 1'b0;
    cap = 1'b1;
    repeat (60) @(posedge sys_clk_i);
    foreach (nb[i]) u_mtx_mac_model.nib_q.push_back(nb[i]);
    t = 0;
    while ((u_mtx_mac_model.nib_q.size() > 0 || u_mtx_mac_model.busy_o) && t < 3000) begin
      @(posedge sys_clk_i);
      t++;
    end
    check(16'(t < 3000), 16'h0001);
    repeat (60) @(posedge sys_clk_i);
    cap = 1'b0;
  endtask

  // Idle is all ones, so the leading idle gives the key stream directly;
  // both tap orders are tried so the bit order of the scrambler is not assumed
  task automatic judge(input logic [4:0] ex[$]);
    logic k[$];
    logic [4:0] s;
    int p;
    int lead;
    int va;
    int vb;
    va = 0;
    vb = 0;
    foreach (bits[i]) k.push_back(~bits[i]);
    for (int n = 11; n < 40; n++) begin
      va += int'(k[n] != (k[n-11] ^ k[n-9]));
      vb += int'(k[n] != (k[n-11] ^ k[n-2]));
    end
    for (int n = 40; n < bits.size(); n++) k[n] = (va == 0) ? (k[n-11] ^ k[n-9]) : (k[n-11] ^ k[n-2]);
    p = 40;
    while (p < bits.size() && (bits[p] ^ k[p])) p++;
    lead = 0;
    while (lead < 5 && ex[0][4-lead]) lead++;
    p -= lead;
    foreach (ex[j]) begin
      for (int b = 0; b < 5; b++) s[4-b] = bits[p+5*j+b] ^ k[p+5*j+b];
      check(16'(s), 16'(ex[j]));
    end
  endtask

  task automatic sc_isolate();
    logic [15:0] v;
    check(16'(oe), 16'h0000);
    reg_rd(mtx_pkg::REG_STAT, v);
    check(v & 16'h0004, 16'h0004);
  endtask

  task automatic sc_regs();
    logic [15:0] v;
    logic [15:0] e;
    e = {7'h00, strap[0], strap[1], strap[2], strap[3], strap[4], 4'h0};
    reg_rd(mtx_pkg::REG_ADDR, v);
    check(v, e);
    reg_wr(mtx_pkg::REG_ADDR, 16'h0000);
    reg_rd(mtx_pkg::REG_ADDR, v);
    check(v, e);
    reg_rd(mtx_pkg::REG_CTRL, v);
    check(v & 16'h8900, 16'h8800);
    reg_rd(5'h1f, v);
    check(v, 16'h0000);
  endtask

  task automatic sc_pins();
    logic [15:0] v;
    int a;
    int b;
    check(16'(oe), 16'h0001);
    flt <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    check(16'(oe), 16'h0000);
    flt <= 1'b0;
    tst <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    check(16'(oe), 16'h0001);
    reg_rd(mtx_pkg::REG_STAT, v);
    check(v & 16'h0008, 16'h0008);
    tst <= 1'b0;
    // Sample off the edge so a coinciding clock rise is never raced
    #2 a = ntx;
    b = nrx;
    repeat (100) @(posedge sys_clk_i);
    #2 check(16'(ntx - a), 16'h0014);
    check(16'(nrx - b), 16'h0014);
    @(posedge sys_clk_i);
    reg_rd(mtx_pkg::REG_STAT, v);
    check(v & 16'h0008, 16'h0000);
  endtask

  task automatic sc_tx();
    logic [4:0] nb[$];
    logic [4:0] ex[$];
    logic [15:0] v;
    reg_wr(mtx_pkg::REG_CTRL, 16'h0000);
    nb = '{5'h05, 5'h05, 5'h05, 5'h0d};
    ex = '{5'h18, 5'h11, tab[5], tab[13]};
    for (int i = 0; i < 16; i++) begin
      nb.push_back(5'(i));
      ex.push_back(tab[i]);
    end
    nb = {nb, 5'h17, 5'h0e};
    ex = {ex, 5'h04, tab[14], 5'h0d, 5'h07, 5'h1f, 5'h1f};
    run_frame(nb);
    judge(ex);
    check(16'(crs_hi), 16'h0001);
    check(16'(crs), 16'h0000);
    // One coded frame ended; the count clears on read
    reg_rd(mtx_pkg::REG_TXCNT, v);
    check(v, 16'h0001);
    reg_rd(mtx_pkg::REG_TXCNT, v);
    check(v, 16'h0000);
    // Bypass with repeater mode: raw symbols, carrier from receive only
    reg_wr(mtx_pkg::REG_CTRL, 16'h8800);
    run_frame('{5'h03, 5'h0a, 5'h15});
    judge('{5'h03, 5'h0a, 5'h15, 5'h1f, 5'h1f});
    check(16'(crs_hi), 16'h0000);
  endtask

  task automatic sc_rx();
    logic [4:0] sy[$] = '{5'h18, 5'h11, 5'h15, 5'h16, 5'h00, 5'h0d, 5'h07, 5'h1f, 5'h1f};
    logic [15:0] v;
    rxq = {};
    rxer = 0;
    foreach (sy[i]) begin
      rx_sym <= sy[i];
      rx_vld <= 1'b1;
      @(posedge sys_clk_i);
      rx_sym <= ~sy[i];
      rx_vld <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
    end
    repeat (20) @(posedge sys_clk_i);
    check({rxq[0], rxq[1], rxq[2], rxq[3]}, 16'h553a);
    check(16'(rxq.size()), 16'h0004);
    check(16'(rxer > 0), 16'h0001);
    check(16'(mrx.dv), 16'h0000);
    // Only the invalid code group counts as a receive error
    reg_rd(mtx_pkg::REG_RXERR, v);
    check(v, 16'h0001);
  endtask

  // Test mode: encoder looped into decoder, full duplex set
  task automatic sc_loop();
    tst <= 1'b1;
    reg_wr(mtx_pkg::REG_CTRL, 16'h0100);
    rxq = {};
    run_frame('{5'h05, 5'h05, 5'h05, 5'h0d, 5'h01, 5'h02});
    check({rxq[0], rxq[1], rxq[2], rxq[3]}, 16'h555d);
    check({rxq[4], rxq[5], 8'h00}, 16'h1200);
    check(16'(rxq.size()), 16'h0006);
    check(16'(crs_hi), 16'h0001);
    tst <= 1'b0;
  endtask

  initial begin
    do_reset(5'h00, 1'b0, 1'b0);
    sc_isolate();
    do_reset(5'h16, 1'b1, 1'b1);
    sc_regs();
    sc_pins();
    sc_tx();
    sc_rx();
    sc_loop();
    close_out();
  end

  // Whole run needs under a thousand cycles; stop a hang well beyond that
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    close_out();
  end
endmodule
